// *** src/sdpin_addr_mux.sv ***
// Row/column address selector for the multiplexed SDRAM address pins.
// Assumes the caller registers the result before it reaches a pin.
`timescale 1ns/1ps
`default_nettype none
module sdpin_addr_mux #(
  parameter int unsigned ADDR_W = 13
) (
  input wire logic [ADDR_W-1:0] row_addr,
  input wire logic [ADDR_W-1:0] col_addr,
  input wire logic use_col,
  output logic [ADDR_W-1:0] pin_addr
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 16) begin
      $error("sdpin_addr_mux: ADDR_W out of range");
    end
  end

  // Column phase shares the same pins as the row phase
  assign pin_addr = use_col ? col_addr : row_addr;

endmodule
`default_nettype wire

// *** src/sdpin_if.sv ***
// SDRAM pin interface: turns controller commands into registered strobes,
// selects, masks and address, and drives the memory clock out.
// Assumes the controller core sits on mclk and holds a command until taken;
// the memories sample on rising edges of bus_clock_out.
// No protocol timing is kept here; the core spaces its own commands.
`timescale 1ns/1ps
`default_nettype none
module sdpin_if
  import sdpin_pkg::*;
#(
  parameter int unsigned ADDR_W = 13
) (
  input wire logic mclk,
  input wire logic reset,
  // Field of the DRAM control register, held by the register file outside
  input wire logic command_on_clock_enable,
  // Command port from the controller core
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic cmd_block,
  input wire logic [ADDR_W-1:0] cmd_row_addr,
  input wire logic [ADDR_W-1:0] cmd_col_addr,
  input wire logic [SDPIN_LANES-1:0] cmd_byte_enable,
  input wire logic cmd_extra_bit,
  output logic sdram_suspended,
  // SDRAM pins
  output logic bus_clock_out,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic dram_read_write,
  output logic [SDPIN_BLOCKS-1:0] sdram_block_select_n,
  output logic sdram_clock_enable,
  output logic [SDPIN_LANES-1:0] byte_strobe,
  output logic [ADDR_W-1:0] sdram_addr
);

  // Elaboration checks: the select decode and the lane masks below are
  // written for two blocks and four lanes, and the divider for two
  initial begin
    if (SDPIN_MCLK_PER_BUS_CLK != 2) begin
      $error("sdpin_if: only a divide-by-two memory clock is served");
    end
    if (SDPIN_BLOCKS != 2) begin
      $error("sdpin_if: the select decode serves exactly two blocks");
    end
    if (SDPIN_LANES != 4) begin
      $error("sdpin_if: the byte strobe path serves exactly four lanes");
    end
    if (ADDR_W < 8 || ADDR_W > 16) begin
      $error("sdpin_if: ADDR_W out of range");
    end
  end

  // Whole state in one record: every pin is a field, so every pin leaves
  // from a flip-flop; suspended is the core's view of a power-down that the
  // clock enable pin may not show in command-bit mode
  typedef struct packed {
    logic bus_clk;
    logic row_n;
    logic col_n;
    logic write;
    logic [SDPIN_BLOCKS-1:0] select_n;
    logic cke;
    logic suspended;
    logic [SDPIN_LANES-1:0] bstrobe;
    logic [ADDR_W-1:0] addr;
  } sdpin_state_type;

  // Registered state and its next value
  sdpin_state_type state_r;
  sdpin_state_type state_nxt;
  sdpin_op_type op;
  logic take;
  logic use_col;
  logic [ADDR_W-1:0] mux_addr;

  // Code 7 is no member of the type; the decode treats it as a no-operation
  assign op = sdpin_op_type'(cmd_op);

  // Pins may only change on the edge where the memory clock falls,
  // so a command is taken once per memory clock period
  // cmd_ready is no combinational output but a plain copy of a flip-flop
  assign cmd_ready = state_r.bus_clk;
  assign take = cmd_valid && cmd_ready;

  // Only the column commands put the column on the pins
  // column address path
  assign use_col = (op == SDPIN_OP_READ) || (op == SDPIN_OP_WRITE);

  // Address selector; its output is registered below, never driven out raw
  sdpin_addr_mux #(
    .ADDR_W(ADDR_W)
  ) u_addr_mux (
    .row_addr(cmd_row_addr),
    .col_addr(cmd_col_addr),
    .use_col(use_col),
    .pin_addr(mux_addr)
  );

  // Next state: clock divider plus the command decode
  always_comb begin
    state_nxt = state_r;
    state_nxt.bus_clk = ~state_r.bus_clk;
    // Pins change only where the memory clock falls, which leaves them a
    // full mclk period to settle before the memory samples on the rise
    if (state_r.bus_clk) begin
      // Default to a deselected no-operation for this memory cycle
      state_nxt.row_n = 1'b1;
      state_nxt.col_n = 1'b1;
      state_nxt.write = 1'b0;
      state_nxt.select_n = SDPIN_RST_SELECT_N;
      state_nxt.bstrobe = SDPIN_RST_BYTE_STROBE;
      if (take) begin
        state_nxt.select_n = cmd_block ? 2'h1 : 2'h2;
        // Address loads on every take; it is ignored while no strobe is low
        state_nxt.addr = mux_addr;
        // Refresh and mode-register loads are not offered here: both strobe
        // the column with no column address on the pins
        unique case (op)
          SDPIN_OP_NOP: begin
            state_nxt.select_n = SDPIN_RST_SELECT_N;
          end
          SDPIN_OP_ACTIVATE: begin
            state_nxt.row_n = 1'b0;
          end
          SDPIN_OP_READ: begin
            // Column address with the write line low reads
            // lane masks on read
            state_nxt.col_n = 1'b0;
            state_nxt.bstrobe = ~cmd_byte_enable;
          end
          SDPIN_OP_WRITE: begin
            state_nxt.col_n = 1'b0;
            state_nxt.write = 1'b1;
            state_nxt.bstrobe = ~cmd_byte_enable;
          end
          SDPIN_OP_PRECHARGE: begin
            // The write line is part of the precharge command code
            // row address held on pins
            state_nxt.row_n = 1'b0;
            state_nxt.write = 1'b1;
          end
          SDPIN_OP_SUSPEND: begin
            // No block selected: power-down entry is the clock enable alone
            state_nxt.select_n = SDPIN_RST_SELECT_N;
            state_nxt.suspended = 1'b1;
          end
          SDPIN_OP_RESUME: begin
            // Normal mode lifts the clock enable again in this same slot
            state_nxt.select_n = SDPIN_RST_SELECT_N;
            state_nxt.suspended = 1'b0;
          end
          default: begin
            // Unused code behaves as a no-operation
            state_nxt.select_n = SDPIN_RST_SELECT_N;
          end
        endcase
      end

      // The mode bit is sampled only in ready slots, so a change in mid-cycle
      // never shortens a clock enable level below one memory clock
      // clock enable mode select
      if (command_on_clock_enable) begin
        state_nxt.cke = take ? cmd_extra_bit : 1'b1;
      end else begin
        state_nxt.cke = ~state_nxt.suspended;
      end
    end
  end

  // State register; reset leaves the memories deselected and clocked.
  // Reset is synchronous and loads constants only, so the pins come out
  // of reset at a defined level right after the first mclk edge that samples it
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r.bus_clk <= SDPIN_RST_BUS_CLK;
      state_r.row_n <= SDPIN_RST_STROBE_N;
      state_r.col_n <= SDPIN_RST_STROBE_N;
      state_r.write <= SDPIN_RST_WRITE;
      state_r.select_n <= SDPIN_RST_SELECT_N;
      state_r.cke <= SDPIN_RST_CKE;
      state_r.suspended <= 1'b0;
      state_r.bstrobe <= SDPIN_RST_BYTE_STROBE;
      state_r.addr <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // No gate between flip-flop and pin: output timing is clock-to-out alone,
  // and the pins cannot glitch between memory clock edges
  // all pins from flip-flops
  assign bus_clock_out = state_r.bus_clk;
  assign row_strobe_n = state_r.row_n;
  assign column_strobe_n = state_r.col_n;
  assign dram_read_write = state_r.write;
  assign sdram_block_select_n = state_r.select_n;
  assign sdram_clock_enable = state_r.cke;
  assign byte_strobe = state_r.bstrobe;
  assign sdram_addr = state_r.addr;
  assign sdram_suspended = state_r.suspended;

endmodule
`default_nettype wire

// *** src/sdpin_pkg.sv ***
// Shared constants and types of the SDRAM pin interface.
// Assumes a single 50 MHz clock mclk with synchronous active-high reset.
package sdpin_pkg;

  // Clock rate, and the divide ratio from mclk to the memory clock
  localparam int unsigned SDPIN_MCLK_HZ = 50_000_000;
  localparam int unsigned SDPIN_MCLK_PER_BUS_CLK = 2;
  localparam int unsigned SDPIN_BUS_CLK_HZ = SDPIN_MCLK_HZ / SDPIN_MCLK_PER_BUS_CLK;

  // Pin widths
  localparam int unsigned SDPIN_BLOCKS = 2;
  localparam int unsigned SDPIN_LANES = 4;

  // Values after reset: strobes and selects negated, memory clock enabled
  localparam logic SDPIN_RST_STROBE_N = 1'b1;
  localparam logic SDPIN_RST_WRITE = 1'b0;
  localparam logic SDPIN_RST_CKE = 1'b1;
  localparam logic SDPIN_RST_BUS_CLK = 1'b0;
  localparam logic [SDPIN_BLOCKS-1:0] SDPIN_RST_SELECT_N = 2'h3;
  localparam logic [SDPIN_LANES-1:0] SDPIN_RST_BYTE_STROBE = 4'hF;

  // Commands accepted from the controller core
  typedef enum logic [2:0] {
    SDPIN_OP_NOP = 3'b000,
    SDPIN_OP_ACTIVATE = 3'b001,
    SDPIN_OP_READ = 3'b010,
    SDPIN_OP_WRITE = 3'b011,
    SDPIN_OP_PRECHARGE = 3'b100,
    SDPIN_OP_SUSPEND = 3'b101,
    SDPIN_OP_RESUME = 3'b110
  } sdpin_op_type;

endpackage

// *** verification/sdpin_mem_model.sv ***
// Two-block SDRAM stand-in that logs each selected command.
// Pins are taken as settled at rising edges of bus_clock_out.
`timescale 1ns/1ps
`default_nettype none
module sdpin_mem_model #(
  parameter int unsigned ADDR_W = 13
) (
  input wire logic bus_clock_out,
  input wire logic sdram_clock_enable,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic dram_read_write,
  input wire logic [1:0] sdram_block_select_n,
  input wire logic [3:0] byte_strobe,
  input wire logic [ADDR_W-1:0] sdram_addr
);
  logic [ADDR_W+8:0] log_q[$];
  // Sample as one command
  // Deselected cycles are skipped, and a low clock enable freezes the memory
  always @(posedge bus_clock_out) begin
    if (sdram_clock_enable && sdram_block_select_n != 2'h3) begin
      log_q.push_back({row_strobe_n, column_strobe_n, dram_read_write, sdram_block_select_n, byte_strobe, sdram_addr});
    end
  end
endmodule
`default_nettype wire

// *** verification/sdpin_sva.sv ***
// Pin-level checks for sdpin_if.
// Bound to the design top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sdpin_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic command_on_clock_enable,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic bus_clock_out,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic dram_read_write,
  input wire logic [1:0] sdram_block_select_n,
  input wire logic sdram_clock_enable,
  input wire logic [3:0] byte_strobe
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  // A command is taken only in the ready slot
  wire tk = cmd_valid && cmd_ready;
  row_act_a: assert property (tk && cmd_op == 3'h1 |=> !row_strobe_n && column_strobe_n) else $error("row");
  col_rd_a: assert property (tk && cmd_op == 3'h2 |=> !column_strobe_n && !dram_read_write) else $error("rd");
  col_wr_a: assert property (tk && cmd_op == 3'h3 |=> !column_strobe_n && dram_read_write) else $error("wr");
  sel_one_a: assert property (!row_strobe_n || !column_strobe_n |-> $onehot(~sdram_block_select_n)) else $error("sel");
  clk_tgl_a: assert property (!reset |=> bus_clock_out != $past(bus_clock_out)) else $error("clk");
  rdy_slot_a: assert property (!reset |=> cmd_ready != $past(cmd_ready)) else $error("ready slot");
  pin_hold_a: assert property (!bus_clock_out |=> $stable({row_strobe_n, column_strobe_n, byte_strobe})) else $error("hold");
  nop_idle_a: assert property (cmd_ready && !cmd_valid |=> sdram_block_select_n == 2'h3 && byte_strobe == 4'hF) else $error("nop");
  cke_low_a: assert property (tk && !command_on_clock_enable && cmd_op == 3'h5 |=> !sdram_clock_enable [*2]) else $error("cke");
  cke_cmd_a: assert property (command_on_clock_enable && cmd_ready && !cmd_valid |=> sdram_clock_enable) else $error("bit");
  cover property (tk && cmd_op == 3'h3);
  cover property (tk && cmd_op == 3'h5);
  cover property (tk && command_on_clock_enable);
  cover property (tk && command_on_clock_enable && cmd_op == 3'h5);
endmodule
`default_nettype wire

// *** verification/test_sdram_pin_interface.sv ***
// Bench for sdpin_if: drives commands, reads the memory log.
// Assumes the memory model logs selected commands in order.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH %0t pin", $time); end end
module test_sdram_pin_interface;
  import sdpin_pkg::*;
  logic mclk = '0, reset = '1, command_on_clock_enable = '0, cmd_valid = '0, cmd_block = '0, cmd_extra_bit = '0;
  logic [2:0] cmd_op = '0;
  logic [12:0] cmd_row_addr = '0, cmd_col_addr = '0, sdram_addr;
  logic [3:0] cmd_byte_enable = '0, byte_strobe;
  logic [1:0] sdram_block_select_n;
  logic cmd_ready, sdram_suspended, bus_clock_out, row_strobe_n, column_strobe_n, dram_read_write, sdram_clock_enable;
  int error_cnt = 0, n_tests = 0;
  sdpin_if DUT (
    .mclk(mclk),
    .reset(reset),
    .command_on_clock_enable(command_on_clock_enable),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd_op(cmd_op),
    .cmd_block(cmd_block),
    .cmd_row_addr(cmd_row_addr),
    .cmd_col_addr(cmd_col_addr),
    .cmd_byte_enable(cmd_byte_enable),
    .cmd_extra_bit(cmd_extra_bit),
    .sdram_suspended(sdram_suspended),
    .bus_clock_out(bus_clock_out),
    .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n),
    .dram_read_write(dram_read_write),
    .sdram_block_select_n(sdram_block_select_n),
    .sdram_clock_enable(sdram_clock_enable),
    .byte_strobe(byte_strobe),
    .sdram_addr(sdram_addr)
  );
  sdpin_mem_model mem (
    .bus_clock_out(bus_clock_out),
    .sdram_clock_enable(sdram_clock_enable),
    .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n),
    .dram_read_write(dram_read_write),
    .sdram_block_select_n(sdram_block_select_n),
    .byte_strobe(byte_strobe),
    .sdram_addr(sdram_addr)
  );
  initial forever #10 mclk = ~mclk;
  // Hold the command until the ready slot takes it
  task automatic send(input logic [2:0] op, input logic b, input logic [12:0] ra, ca, input logic [3:0] be);
    @(posedge mclk);
    {cmd_op, cmd_block, cmd_row_addr, cmd_col_addr, cmd_byte_enable, cmd_valid} <= {op, b, ra, ca, be, 1'b1};
    do @(negedge mclk); while (cmd_ready !== 1'b1);
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic pop(input logic [2:0] rcw, input logic b, input logic [3:0] dqm, input logic [12:0] a);
    `CHK(mem.log_q.pop_front(), {rcw, ~(2'h1 << b), dqm, a})
  endtask
  // Activate, read, write and precharge on both blocks, back to back
  task automatic t_cmds;
    for (int b = 0; b < 2; b++) begin
      send(3'h1, b[0], 13'h1ABC, '0, '0);
      send(3'h2, b[0], '0, 13'h0155, 4'h5);
      send(3'h3, b[0], '0, 13'h1FFF, 4'hA);
      send(3'h4, b[0], 13'h1ABC, '0, '0);
    end
    repeat (6) @(posedge mclk);
    for (int b = 0; b < 2; b++) begin
      pop(3'h2, b[0], 4'hF, 13'h1ABC);
      pop(3'h4, b[0], 4'hA, 13'h0155);
      pop(3'h5, b[0], 4'h5, 13'h1FFF);
      pop(3'h3, b[0], 4'hF, 13'h1ABC);
    end
    `CHK(mem.log_q.size(), 0)
    $display("cmds end");
  endtask
  // Power-down entry and exit; the memory sees no command
  task automatic t_suspend;
    send(3'h5, 1'b0, '0, '0, '0);
    @(negedge mclk);
    `CHK({sdram_clock_enable, sdram_suspended}, 2'h1)
    send(3'h6, 1'b0, '0, '0, '0);
    @(negedge mclk);
    `CHK({sdram_clock_enable, sdram_suspended}, 2'h2)
    `CHK(mem.log_q.size(), 0)
    $display("suspend end");
  endtask
  // Clock enable pin carries the extra command bit
  task automatic t_cmdbit;
    @(posedge mclk);
    command_on_clock_enable <= 1'b1;
    send(3'h0, 1'b0, '0, '0, '0);
    @(negedge mclk);
    `CHK(sdram_clock_enable, 1'b0)
    repeat (2) @(negedge mclk);
    `CHK(sdram_clock_enable, 1'b1)
    // Suspend in command-bit mode: the pin follows the bit, not the suspend
    @(posedge mclk);
    cmd_extra_bit <= 1'b1;
    send(3'h5, 1'b0, '0, '0, '0);
    @(negedge mclk);
    `CHK({sdram_clock_enable, sdram_suspended}, 2'h3)
    @(posedge mclk);
    cmd_extra_bit <= 1'b0;
    send(3'h6, 1'b0, '0, '0, '0);
    @(negedge mclk);
    `CHK({sdram_clock_enable, sdram_suspended}, 2'h0)
    $display("cmdbit end");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_cmds();
    t_suspend();
    t_cmdbit();
    finish_test();
  end
  // Run needs about fifty cycles; allow two thousand
  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end
endmodule
bind sdpin_if sdpin_sva chk (
  .mclk(mclk),
  .reset(reset),
  .command_on_clock_enable(command_on_clock_enable),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .cmd_op(cmd_op),
  .bus_clock_out(bus_clock_out),
  .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n),
  .dram_read_write(dram_read_write),
  .sdram_block_select_n(sdram_block_select_n),
  .sdram_clock_enable(sdram_clock_enable),
  .byte_strobe(byte_strobe)
);
`default_nettype wire
